// [shared/ebpwm_map.vh]
// Register map, field positions and reset values of the bridge modulator.
// Included by the modulator top module only; holds definitions only.
`ifndef EBPWM_MAP_VH
`define EBPWM_MAP_VH

// Byte offsets on the APB register bus
`define OFS_CAPTURE_PWM_CONTROL  12'h000
`define OFS_DUTY_HIGH_BITS       12'h004
`define OFS_DUTY_BUFFER          12'h008
`define OFS_DEADBAND_RESTART     12'h00C
`define OFS_STEERING_CONTROL     12'h010
`define OFS_TIMEBASE_CONTROL     12'h014
`define OFS_PERIOD_LIMIT         12'h018
`define OFS_TIMEBASE_COUNT       12'h01C
`define OFS_PIN_DIRECTION        12'h020
`define OFS_PIN_STATUS           12'h024

// Fields of capture_pwm_control
`define OUTPUT_MODE_HI           7
`define OUTPUT_MODE_LO           6
`define DUTY_LOW_HI              5
`define DUTY_LOW_LO              4
`define MODE_SEL_HI              3
`define MODE_SEL_LO              0

// Output modes
`define OMODE_SINGLE             2'b00
`define OMODE_FULL_FWD           2'b01
`define OMODE_HALF               2'b10
`define OMODE_FULL_REV           2'b11

// Mode-select codes that select modulation; low two bits set polarity
`define MODE_SEL_PWM_HI          2'b11
`define POL_AC_BIT               1
`define POL_BD_BIT               0

// Timebase control fields
`define TB_ON_BIT                2
`define TB_PRESCALE_HI           1
`define TB_PRESCALE_LO           0

// Reset values
`define RST_BYTE                 8'h00

// Oscillator periods per timer count
`define OSC_PER_COUNT            4

`endif

// [hw/ebpwm_pin_stage.v]
// Per-pin output stage: polarity, port release and pin direction gating.
// Assumes all inputs synchronous to pclk.
`timescale 1ns/1ps
`default_nettype none
module ebpwm_pin_stage #(
    parameter N = 4
) (
    input  wire         pclk,
    input  wire         presetn,
    input  wire [N-1:0] level_in,
    input  wire [N-1:0] active_low,
    input  wire [N-1:0] used,
    input  wire [N-1:0] dir_output,
    output reg  [N-1:0] pin_out_r,
    output reg  [N-1:0] pin_oe_r
);
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_out_r <= {N{1'b0}};
            pin_oe_r  <= {N{1'b0}};
        end else begin
            pin_out_r <= (level_in ^ active_low) & used;
            pin_oe_r  <= used & dir_output;
        end
    end
endmodule // ebpwm_pin_stage
`default_nettype wire

// [hw/enhanced_bridge_pwm.v]
// Enhanced bridge modulator: timer, duty compare, dead band, mode mux, APB slave.
// Assumes APB master on pclk; pins are driven through a tristate pad outside.
`timescale 1ns/1ps
`default_nettype none
`include "ebpwm_map.vh"
module enhanced_bridge_pwm (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    output wire        out_a,
    output wire        out_a_oe,
    output wire        out_b,
    output wire        out_b_oe,
    output wire        out_c,
    output wire        out_c_oe,
    output wire        out_d,
    output wire        out_d_oe
);
    reg  [7:0] capture_pwm_control_r;
    reg  [7:0] duty_high_bits_r;
    reg  [7:0] deadband_restart_control_r;
    reg  [7:0] steering_control_r;
    reg  [7:0] timebase_control_r;
    reg  [7:0] period_limit_r;
    reg  [3:0] pin_direction_r;
    reg  [7:0] timebase_count_r;
    reg  [1:0] sub_count_r;
    reg  [9:0] duty_buffer_r;
    reg        armed_r;
    reg        mod_r;
    reg        mod_b_r;
    reg  [8:0] dead_a_r;
    reg  [8:0] dead_b_r;
    reg  [1:0] latched_mode_r;

    // APB request decode, shared by the time base and the register file
    wire       apb_wr = psel && penable && pwrite;
    wire       apb_rd = psel && !penable && !pwrite;

    wire [1:0] output_mode_field = capture_pwm_control_r[`OUTPUT_MODE_HI:`OUTPUT_MODE_LO];
    wire [3:0] mode_select_bits  = capture_pwm_control_r[`MODE_SEL_HI:`MODE_SEL_LO];
    wire [6:0] deadband_count    = deadband_restart_control_r[6:0];
    wire       pwm_on   = (mode_select_bits[3:2] == `MODE_SEL_PWM_HI);
    wire       tb_on    = timebase_control_r[`TB_ON_BIT];
    wire [9:0] duty_val = {duty_high_bits_r,
                           capture_pwm_control_r[`DUTY_LOW_HI:`DUTY_LOW_LO]};

    // Prescale ratio minus one: 1, 4, 16, 64 oscillator ticks per sub-step
    function [5:0] pre_limit;
        input [1:0] sel;
        begin
            case (sel)
                2'b00:   pre_limit = 6'h00;
                2'b01:   pre_limit = 6'h03;
                2'b10:   pre_limit = 6'h0F;
                default: pre_limit = 6'h3F;
            endcase
        end
    endfunction

    wire [5:0] pre_max = pre_limit(timebase_control_r[`TB_PRESCALE_HI:`TB_PRESCALE_LO]);
    reg  [5:0] pre_cnt_r;
    wire       tick     = tb_on && (pre_cnt_r >= pre_max);
    wire       cnt_end  = tick && (sub_count_r == 2'd3);
    wire       wrap     = cnt_end && (timebase_count_r == period_limit_r);
    wire [9:0] time_base = {timebase_count_r, sub_count_r};
    // Time base value after the coming sub-step; the pin clears as it reaches duty
    wire [9:0] time_next = time_base + 10'h001;

    // Prescaler and 10-bit time base
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_cnt_r        <= 6'h00;
            sub_count_r      <= 2'b00;
            timebase_count_r <= `RST_BYTE;
        end else if (apb_wr && paddr == `OFS_TIMEBASE_COUNT) begin
            timebase_count_r <= pwdata[7:0];
            sub_count_r      <= 2'b00;
            pre_cnt_r        <= 6'h00;
        end else if (tb_on) begin
            pre_cnt_r <= tick ? 6'h00 : pre_cnt_r + 6'h01;
            if (tick) begin
                sub_count_r <= sub_count_r + 2'b01;
                if (wrap)
                    timebase_count_r <= `RST_BYTE;
                else if (cnt_end)
                    timebase_count_r <= timebase_count_r + 8'h01;
            end
        end
    end

    // Duty latch, start hold-off and main modulated level
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            duty_buffer_r  <= 10'h000;
            armed_r        <= 1'b0;
            mod_r          <= 1'b0;
            latched_mode_r <= `OMODE_SINGLE;
        end else if (!pwm_on) begin
            armed_r <= 1'b0;
            mod_r   <= 1'b0;
        end else if (wrap) begin
            duty_buffer_r  <= duty_val;
            armed_r        <= 1'b1;
            mod_r          <= (duty_val != 10'h000);
            latched_mode_r <= output_mode_field;
        end else if (armed_r && tick && time_next == duty_buffer_r) begin
            mod_r <= 1'b0;
        end
    end

    // Dead-band count: four clocks per step, loaded on a turn-on edge
    function [8:0] dead_next;
        input [8:0] cur;
        input       turn_on;
        input [6:0] dead;
        begin
            if (turn_on && dead != 7'h00)
                dead_next = {dead, 2'b00} - 9'h001;
            else if (cur != 9'h000)
                dead_next = cur - 9'h001;
            else
                dead_next = 9'h000;
        end
    endfunction

    wire rise_a  = mod_r && !mod_b_r;
    wire rise_b  = !mod_r && mod_b_r && armed_r;
    wire dead_on = (deadband_count != 7'h00);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dead_a_r <= 9'h000;
            dead_b_r <= 9'h000;
            mod_b_r  <= 1'b0;
        end else begin
            mod_b_r  <= mod_r;
            dead_a_r <= dead_next(dead_a_r, rise_a, deadband_count);
            dead_b_r <= dead_next(dead_b_r, rise_b, deadband_count);
        end
    end

    // Delayed levels; the edge cycle is held off too, a long dead band keeps it off
    wire half_a = mod_r && !(rise_a && dead_on) && (dead_a_r == 9'h000);
    wire half_b = !mod_r && armed_r && !(rise_b && dead_on) && (dead_b_r == 9'h000);

    reg [3:0] level;
    reg [3:0] used;
    always @* begin
        level = 4'b0000;
        used  = 4'b0000;
        case (latched_mode_r)
            `OMODE_SINGLE: begin
                level = {4{mod_r}};
                used  = steering_control_r[3:0];
            end
            `OMODE_HALF: begin
                level = {2'b00, half_b, half_a};
                used  = 4'b0011;
            end
            `OMODE_FULL_FWD: begin
                level = {mod_r, 1'b0, 1'b0, 1'b1};
                used  = 4'b1111;
            end
            `OMODE_FULL_REV: begin
                level = {1'b0, 1'b1, mod_r, 1'b0};
                used  = 4'b1111;
            end
            default: begin
                level = 4'b0000;
                used  = 4'b0000;
            end
        endcase
        if (!armed_r)
            used = 4'b0000;
        if (capture_pwm_control_r == 8'h00)
            used = 4'b0000;
    end

    // Polarity: A/C and B/D pairs set active low by mode-select bits
    wire pol_ac = mode_select_bits[`POL_AC_BIT];
    wire pol_bd = mode_select_bits[`POL_BD_BIT];
    wire [3:0] pin_q;
    wire [3:0] pin_oe;

    ebpwm_pin_stage #(.N(4)) u_pins (
        .pclk       (pclk),
        .presetn    (presetn),
        .level_in   (level),
        .active_low ({pol_bd, pol_ac, pol_bd, pol_ac}),
        .used       (used),
        .dir_output (pin_direction_r),
        .pin_out_r  (pin_q),
        .pin_oe_r   (pin_oe)
    );
    assign out_a    = pin_q[0];
    assign out_b    = pin_q[1];
    assign out_c    = pin_q[2];
    assign out_d    = pin_q[3];
    assign out_a_oe = pin_oe[0];
    assign out_b_oe = pin_oe[1];
    assign out_c_oe = pin_oe[2];
    assign out_d_oe = pin_oe[3];

    // APB slave, zero wait states
    reg  hit;
    always @* begin
        case (paddr)
            `OFS_CAPTURE_PWM_CONTROL, `OFS_DUTY_HIGH_BITS, `OFS_DUTY_BUFFER,
            `OFS_DEADBAND_RESTART, `OFS_STEERING_CONTROL, `OFS_TIMEBASE_CONTROL,
            `OFS_PERIOD_LIMIT, `OFS_TIMEBASE_COUNT, `OFS_PIN_DIRECTION,
            `OFS_PIN_STATUS: hit = 1'b1;
            default:         hit = 1'b0;
        endcase
    end
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !hit;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            capture_pwm_control_r      <= `RST_BYTE;
            duty_high_bits_r           <= `RST_BYTE;
            deadband_restart_control_r <= `RST_BYTE;
            steering_control_r         <= `RST_BYTE;
            timebase_control_r         <= `RST_BYTE;
            period_limit_r             <= `RST_BYTE;
            pin_direction_r            <= 4'h0;
        end else if (apb_wr) begin
            case (paddr)
                `OFS_CAPTURE_PWM_CONTROL: capture_pwm_control_r      <= pwdata[7:0];
                `OFS_DUTY_HIGH_BITS:      duty_high_bits_r           <= pwdata[7:0];
                `OFS_DEADBAND_RESTART:    deadband_restart_control_r <= pwdata[7:0];
                `OFS_STEERING_CONTROL:    steering_control_r         <= {3'b000, pwdata[4:0]};
                `OFS_TIMEBASE_CONTROL:    timebase_control_r         <= {1'b0, pwdata[6:0]};
                `OFS_PERIOD_LIMIT:        period_limit_r             <= pwdata[7:0];
                `OFS_PIN_DIRECTION:       pin_direction_r            <= pwdata[3:0];
                default: ;
            endcase
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (apb_rd) begin
            case (paddr)
                `OFS_CAPTURE_PWM_CONTROL: prdata <= {24'h000000, capture_pwm_control_r};
                `OFS_DUTY_HIGH_BITS:      prdata <= {24'h000000, duty_high_bits_r};
                `OFS_DUTY_BUFFER:         prdata <= {22'h0, duty_buffer_r};
                `OFS_DEADBAND_RESTART:    prdata <= {24'h000000, deadband_restart_control_r};
                `OFS_STEERING_CONTROL:    prdata <= {24'h000000, steering_control_r};
                `OFS_TIMEBASE_CONTROL:    prdata <= {24'h000000, timebase_control_r};
                `OFS_PERIOD_LIMIT:        prdata <= {24'h000000, period_limit_r};
                `OFS_TIMEBASE_COUNT:      prdata <= {24'h000000, timebase_count_r};
                `OFS_PIN_DIRECTION:       prdata <= {28'h0000000, pin_direction_r};
                `OFS_PIN_STATUS:          prdata <= {23'h0, armed_r, pin_oe, pin_q};
                default:                  prdata <= 32'h0000_0000;
            endcase
        end
    end
endmodule // enhanced_bridge_pwm
`default_nettype wire

// [tb/ebpwm_monitor.sv]
// Checker of the bridge modulator pins and bus, bound to its top module.
// Assumes one clock pclk and an asynchronous active-low presetn.
`timescale 1ns/1ps
`default_nettype none
module ebpwm_monitor (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic        pready,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        out_a,
    input wire logic        out_a_oe,
    input wire logic        out_b,
    input wire logic        out_b_oe,
    input wire logic        out_c,
    input wire logic        out_c_oe,
    input wire logic        out_d,
    input wire logic        out_d_oe
);
    logic [7:0]  ctrl_r, steer_r, dir_r, pl_r;
    logic [1:0]  ps_r;
    logic [19:0] quiet_r;
    wire  [19:0] wait_len;
    wire         wr = psel & penable & pwrite & pready;
    wire  [3:0]  oe = {out_d_oe, out_c_oe, out_b_oe, out_a_oe};
    wire  [3:0]  lv = {out_d, out_c, out_b, out_a};
    wire         settled = quiet_r > wait_len;
    wire  [1:0]  md = ctrl_r[7:6];
    // Two full periods after the last register write
    assign wait_len = ((20'(pl_r) + 20'h1) << (3 + 2 * ps_r)) + 20'h8;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {ctrl_r, steer_r, dir_r, pl_r, ps_r} <= 34'h0;
            quiet_r <= 20'h0;
        end else if (wr) begin
            quiet_r <= 20'h0;
            case (paddr)
                12'h000: ctrl_r <= pwdata[7:0];
                12'h010: steer_r <= pwdata[7:0];
                12'h014: ps_r <= pwdata[1:0];
                12'h018: pl_r <= pwdata[7:0];
                12'h020: dir_r <= pwdata[7:0];
                default: ;
            endcase
        end else if (quiet_r != 20'hFFFFF) begin
            quiet_r <= quiet_r + 20'h1;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_zero_write; wr && paddr == 12'h000 && pwdata[7:0] == 8'h00; endsequence
    sequence s_first_on; wr && paddr == 12'h000 && pwdata[7:0] != 8'h00 && ctrl_r == 8'h00;
    endsequence
    property p_reset_idle; $rose(presetn) |-> (oe == 4'h0) [*2]; endproperty
    property p_first_wait; s_first_on |=> (oe == 4'h0) [*2]; endproperty
    property p_zero_release; s_zero_write |-> ##2 (oe == 4'h0) [*3]; endproperty
    property p_dir_gate; $past(dir_r) == dir_r |-> (oe & ~dir_r[3:0]) == 4'h0; endproperty
    property p_half_free; settled && md == 2'b10 |-> oe[3:2] == 2'b00; endproperty
    property p_single_steer; settled && md == 2'b00 |-> (oe[3:1] & ~steer_r[3:1]) == 3'h0;
    endproperty
    property p_full_fwd; settled && md == 2'b01 && ctrl_r[3:2] == 2'b11 && (&oe[2:0])
        |-> lv[0] == !ctrl_r[1] && lv[1] == ctrl_r[0] && lv[2] == ctrl_r[1]; endproperty
    property p_full_rev; settled && md == 2'b11 && ctrl_r[3:2] == 2'b11 && (&oe[3:2]) && oe[0]
        |-> lv[0] == ctrl_r[1] && lv[2] == !ctrl_r[1] && lv[3] == ctrl_r[0]; endproperty
    property p_half_gap; settled && md == 2'b10 && (&oe[1:0])
        |-> !((lv[0] ^ ctrl_r[1]) && (lv[1] ^ ctrl_r[0])); endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("pins driven after reset");
    a_first_wait: assert property (p_first_wait) else $error("pins driven at enable");
    a_zero_release: assert property (p_zero_release) else $error("pins kept");
    a_dir_gate: assert property (p_dir_gate) else $error("pin driven as input");
    a_half_free: assert property (p_half_free) else $error("c or d driven");
    a_single_steer: assert property (p_single_steer) else $error("unsteered pin");
    a_full_fwd: assert property (p_full_fwd) else $error("forward levels");
    a_full_rev: assert property (p_full_rev) else $error("reverse levels");
    a_half_gap: assert property (p_half_gap) else $error("both switches on");
endmodule // ebpwm_monitor
bind enhanced_bridge_pwm ebpwm_monitor ebpwm_monitor_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready), .paddr(paddr),
    .pwdata(pwdata), .out_a(out_a), .out_a_oe(out_a_oe), .out_b(out_b), .out_b_oe(out_b_oe),
    .out_c(out_c), .out_c_oe(out_c_oe), .out_d(out_d), .out_d_oe(out_d_oe));
`default_nettype wire

// [tb/power_stage_model.sv]
// Gate driver inputs of the bridge switches on the four modulator pins.
// Assumes each pin line carries a pull-down when the modulator releases it.
`timescale 1ns/1ps
`default_nettype none
module power_stage_model (
    input  wire logic [3:0] drv,
    input  wire logic [3:0] drv_oe,
    output wire logic [3:0] pin_lvl
);
    // Released pins fall to the pull-down level
    assign pin_lvl = drv & drv_oe;
endmodule // power_stage_model
`default_nettype wire

// [tb/tb_top.sv]
// Self-checking bench of the bridge modulator over APB with a switch model.
// Assumes pclk at 125 MHz and the register offsets of the design map.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin err_count++; \
    $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module tb_top;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, er;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, rd;
    wire  [31:0] prdata;
    wire         pready, pslverr;
    wire  [3:0]  drv, oe, lvl;
    int          err_count = 0, samples_checked = 0, cnt[4];
    always #4 pclk = ~pclk;
    enhanced_bridge_pwm enhanced_bridge_pwm_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .out_a(drv[0]), .out_a_oe(oe[0]), .out_b(drv[1]),
        .out_b_oe(oe[1]), .out_c(drv[2]), .out_c_oe(oe[2]), .out_d(drv[3]), .out_d_oe(oe[3]));
    power_stage_model power_stage_model_inst (.drv(drv), .drv_oe(oe), .pin_lvl(lvl));
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) err_count++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task meas(input int w, input int n);
        repeat (w) @(posedge pclk);
        cnt = '{0, 0, 0, 0};
        repeat (n) begin
            @(negedge pclk);
            for (int i = 0; i < 4; i++) cnt[i] += int'(lvl[i]);
        end
    endtask
    task t_reset;
        `CHK("oe", 4'h0, oe)
        for (int i = 0; i < 10; i++) begin
            apb(1'b0, 12'(i * 4), 32'h0);
            `CHK("reg", 32'h0, rd)
        end
        apb(1'b0, 12'h0FC, 32'h0);
        `CHK("unmapped err", 1'b1, er)
        $display("reset test done");
    endtask
    task t_single;
        apb(1'b1, 12'h018, 32'h03);
        apb(1'b1, 12'h014, 32'h04);
        apb(1'b1, 12'h020, 32'h0F);
        apb(1'b1, 12'h010, 32'h01);
        apb(1'b1, 12'h004, 32'h01);
        apb(1'b1, 12'h000, 32'h2C);
        @(negedge pclk);
        `CHK("first oe", 4'h0, oe)
        meas(40, 16);
        `CHK("width", 6, cnt[0])
        `CHK("unsteered oe", 3'h0, oe[3:1])
        apb(1'b0, 12'h008, 32'h0);
        `CHK("duty latch", 32'h6, rd)
        apb(1'b1, 12'h010, 32'h03);
        meas(40, 16);
        `CHK("steered b", 6, cnt[1])
        apb(1'b1, 12'h014, 32'h05);
        meas(150, 64);
        `CHK("prescaled", 24, cnt[0])
        apb(1'b1, 12'h014, 32'h04);
        $display("single test done");
    endtask
    task automatic t_full;
        logic [7:0] md[2] = '{8'h6C, 8'hEC};
        int ex[2][4] = '{'{16, 0, 0, 6}, '{0, 6, 16, 0}};
        for (int m = 0; m < 2; m++) begin
            apb(1'b1, 12'h000, {24'h0, md[m]});
            meas(40, 16);
            `CHK("full oe", 4'hF, oe)
            for (int i = 0; i < 4; i++) `CHK("full pin", ex[m][i], cnt[i])
        end
        $display("full test done");
    endtask
    task t_half;
        apb(1'b1, 12'h018, 32'h07);
        apb(1'b1, 12'h004, 32'h03);
        apb(1'b1, 12'h00C, 32'h01);
        apb(1'b1, 12'h000, 32'h8C);
        meas(80, 32);
        `CHK("half cd oe", 2'b00, oe[3:2])
        `CHK("half a", 8, cnt[0])
        `CHK("half b", 16, cnt[1])
        apb(1'b1, 12'h00C, 32'h04);
        meas(80, 32);
        `CHK("late a", 0, cnt[0])
        `CHK("late b", 4, cnt[1])
        $display("half test done");
    endtask
    task t_pol;
        apb(1'b1, 12'h00C, 32'h00);
        apb(1'b1, 12'h018, 32'h03);
        apb(1'b1, 12'h01C, 32'h00);
        apb(1'b1, 12'h004, 32'h01);
        apb(1'b1, 12'h000, 32'h2F);
        meas(40, 16);
        `CHK("low a", 10, cnt[0])
        `CHK("low b", 10, cnt[1])
        $display("polarity test done");
    endtask
    task t_zero;
        apb(1'b1, 12'h004, 32'h00);
        apb(1'b1, 12'h000, 32'h0C);
        meas(40, 16);
        `CHK("zero duty", 0, cnt[0])
        `CHK("zero duty oe", 1'b1, oe[0])
        apb(1'b1, 12'h000, 32'h00);
        repeat (3) @(posedge pclk);
        `CHK("released", 4'h0, oe)
        apb(1'b1, 12'h020, 32'h00);
        apb(1'b1, 12'h004, 32'h01);
        apb(1'b1, 12'h000, 32'h2C);
        repeat (40) @(posedge pclk);
        `CHK("no dir", 4'h0, oe)
        $display("release test done");
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_single;
        t_full;
        t_half;
        t_pol;
        t_zero;
        test_done;
    end
    initial begin
        #100000;
        err_count++;
        test_done;
    end
endmodule // tb_top
`default_nettype wire
